// [logic/serial_link_config_supervisor.sv]
// Purpose: Settings registers, frame filter, reply pacing, request-to-send and
//          loss-of-communication supervision for a two-pair serial port.
// Assumes: Avalon-MM slave with waitrequest, byte addresses, lane 0 carries written fields.
// Notes:   Link settings take effect only through a restart command.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module serial_link_config_supervisor #(
  parameter int MS_TICK_CYCLES = serial_link_pkg::MS_CYCLES,    // Clocks per millisecond
  parameter int LOSS_LIMIT_MS  = serial_link_pkg::COMM_LOSS_MS  // Silence before fault
) (
  input  wire logic        mclk,            // 20 MHz system clock
  input  wire logic        sys_rst,         // Synchronous reset, high
  input  wire logic [5:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  input  wire logic [31:0] avs_writedata,   // Write data
  output logic [31:0]      avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  input  wire logic        rxd,             // Receive pin
  output logic             txd,             // Transmit pin
  output logic             rts,             // Request-to-send pin
  output logic             comm_fault,      // Communication loss fault
  output logic [1:0]       stop_action,     // Selected stopping method
  output logic             stop_request     // Fault asks the drive to stop
);
  import serial_link_pkg::*;

  localparam logic [15:0] MS_LAST   = 16'(MS_TICK_CYCLES - 1);
  localparam logic [15:0] LOSS_LIM  = 16'(LOSS_LIMIT_MS);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        rxd_meta;
  logic        rxd_sync;
  logic [7:0]  node_set;
  logic [2:0]  rate_set;
  logic [1:0]  parity_set;
  logic [1:0]  action_set;
  logic        detect_en;
  logic [6:0]  delay_set;
  logic        rts_mode;
  link_cfg_t   active;
  logic [15:0] ms_cnt;
  logic        ms_tick;
  logic [5:0]  gap_cnt;
  logic        in_frame;
  logic        frame_match;
  logic        frame_end_ok;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_overrun;
  logic        rx_perr;
  logic [7:0]  tx_data;
  logic        tx_pending;
  logic        tx_start;
  logic [6:0]  delay_left;
  logic [15:0] silence_ms;
  status_t     status;
  wire logic        tx_busy;
  wire logic        bit_tick;
  wire logic        rx_strobe;
  wire logic [7:0]  rx_byte;
  wire logic        rx_parity_err;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic       bus_req   = avs_read | avs_write;
  wire logic       bus_take  = bus_req & ~avs_waitrequest;
  wire logic       wr_en     = bus_take & avs_write & avs_byteenable[0];
  wire logic       rd_take   = bus_take & avs_read;
  wire logic [7:0] wd        = avs_writedata[7:0];
  wire logic       next_wait = ~(bus_req & avs_waitrequest);

  wire logic sel_node    = (avs_address == OFF_NODE);
  wire logic sel_rate    = (avs_address == OFF_RATE);
  wire logic sel_parity  = (avs_address == OFF_PARITY);
  wire logic sel_action  = (avs_address == OFF_ACTION);
  wire logic sel_detect  = (avs_address == OFF_DETECT);
  wire logic sel_delay   = (avs_address == OFF_DELAY);
  wire logic sel_rts     = (avs_address == OFF_RTS);
  wire logic sel_control = (avs_address == OFF_CONTROL);
  wire logic sel_status  = (avs_address == OFF_STATUS);
  wire logic sel_rx      = (avs_address == OFF_RX_DATA);
  wire logic sel_tx      = (avs_address == OFF_TX_DATA);
  wire logic sel_active  = (avs_address == OFF_ACTIVE);

  // Out-of-range setting values are ignored so a setting never leaves its range
  wire logic wr_node    = wr_en & sel_node   & (wd <= NODE_MAX);
  wire logic wr_rate    = wr_en & sel_rate   & (wd <= RATE_MAX);
  wire logic wr_parity  = wr_en & sel_parity & (wd <= PARITY_MAX);
  wire logic wr_action  = wr_en & sel_action & (wd <= ACTION_MAX);
  wire logic wr_detect  = wr_en & sel_detect & (wd <= BOOL_MAX);
  wire logic wr_delay   = wr_en & sel_delay  & (wd >= DELAY_MIN) & (wd <= DELAY_MAX);
  wire logic wr_rts     = wr_en & sel_rts    & (wd <= BOOL_MAX);
  wire logic restart    = wr_en & sel_control & wd[CTRL_RESTART_BIT];
  wire logic fault_clr  = wr_en & sel_control & wd[CTRL_CLEAR_BIT];
  wire logic wr_tx      = wr_en & sel_tx & ~tx_pending;
  wire logic rd_rx      = rd_take & sel_rx;

  assign status = '{in_frame: in_frame, comm_fault: comm_fault, tx_busy: tx_busy,
                    tx_ready: ~tx_pending, rx_parity_err: rx_perr,
                    rx_overrun: rx_overrun, rx_valid: rx_valid};

  wire logic [31:0] rd_mux =
    sel_node   ? 32'(node_set)   :
    sel_rate   ? 32'(rate_set)   :
    sel_parity ? 32'(parity_set) :
    sel_action ? 32'(action_set) :
    sel_detect ? 32'(detect_en)  :
    sel_delay  ? 32'(delay_set)  :
    sel_rts    ? 32'(rts_mode)   :
    sel_status ? 32'(status)     :
    sel_rx     ? 32'(rx_data)    :
    sel_tx     ? 32'(tx_data)    :
    sel_active ? 32'(active)     : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one stall cycle, then data stands with waitrequest low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= next_wait;
      if (bus_req && avs_waitrequest) avs_readdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      node_set   <= NODE_DEFAULT;
      rate_set   <= RATE_DEFAULT;
      parity_set <= PAR_NONE;
      action_set <= ACT_ALARM;
      detect_en  <= DETECT_DEFAULT;
      delay_set  <= DELAY_DEFAULT;
      rts_mode   <= RTS_DEFAULT;
    end else begin
      if (wr_node)   node_set   <= wd;
      if (wr_rate)   rate_set   <= wd[2:0];
      if (wr_parity) parity_set <= wd[1:0];
      if (wr_action) action_set <= wd[1:0];
      if (wr_detect) detect_en  <= wd[0];
      if (wr_delay)  delay_set  <= wd[6:0];
      if (wr_rts)    rts_mode   <= wd[0];
    end
  end

  // Stored link settings reach the link only on restart, like a power cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      active <= '{node: NODE_DEFAULT, rate: RATE_DEFAULT, parity: PAR_NONE};
    end else if (restart) begin
      active <= '{node: node_set, rate: rate_set, parity: parity_set};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and character engine
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
    end
  end

  uart_char_engine u_engine (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .rxd_sync      (rxd_sync),
    .cfg           (active),
    .tx_start      (tx_start),
    .tx_byte       (tx_data),
    .txd           (txd),
    .tx_busy       (tx_busy),
    .bit_tick      (bit_tick),
    .rx_strobe     (rx_strobe),
    .rx_byte       (rx_byte),
    .rx_parity_err (rx_parity_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame tracking: first byte of a frame is the station address
  wire logic first_byte  = rx_strobe & ~in_frame;
  wire logic byte_for_us = rx_strobe & (in_frame ? frame_match : (rx_byte == active.node));
  wire logic gap_done    = in_frame & bit_tick & (gap_cnt == FRAME_GAP_BITS - 6'h1);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      in_frame     <= 1'b0;
      frame_match  <= 1'b0;
      gap_cnt      <= '0;
      frame_end_ok <= 1'b0;
    end else begin
      frame_end_ok <= gap_done & frame_match;
      if (rx_strobe) begin
        in_frame <= 1'b1;
        gap_cnt  <= '0;
        if (first_byte) frame_match <= (rx_byte == active.node);
      end else if (gap_done) begin
        in_frame <= 1'b0;
      end else if (in_frame && bit_tick) begin
        gap_cnt <= gap_cnt + 6'h1;
      end
    end
  end

  // Receive holding register; arrival wins over a same-cycle read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_data    <= '0;
      rx_valid   <= 1'b0;
      rx_overrun <= 1'b0;
      rx_perr    <= 1'b0;
    end else if (byte_for_us) begin
      rx_data    <= rx_byte;
      rx_valid   <= 1'b1;
      rx_perr    <= rx_parity_err;
      rx_overrun <= rx_overrun | (rx_valid & ~rd_rx);
    end else if (rd_rx) begin
      rx_valid   <= 1'b0;
      rx_overrun <= 1'b0;
      rx_perr    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond enable, restarted at frame end so the reply delay is exact
  always_ff @(posedge mclk) begin
    if (sys_rst || frame_end_ok || ms_cnt == MS_LAST) begin
      ms_cnt  <= '0;
      ms_tick <= ~sys_rst & ~frame_end_ok;
    end else begin
      ms_cnt  <= ms_cnt + 16'h1;
      ms_tick <= 1'b0;
    end
  end

  // Reply pacing: a queued byte leaves only once the delay has run out
  wire logic launch = tx_pending & ~tx_busy & ~tx_start & (delay_left == '0);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      delay_left <= '0;
      tx_data    <= '0;
      tx_pending <= 1'b0;
      tx_start   <= 1'b0;
    end else begin
      tx_start <= launch;
      if (frame_end_ok) delay_left <= delay_set;
      else if (ms_tick && delay_left != '0) delay_left <= delay_left - 7'h1;
      if (wr_tx) begin
        tx_data    <= wd;
        tx_pending <= 1'b1;
      end else if (launch) begin
        tx_pending <= 1'b0;
      end
    end
  end

  // Held high in mode 0; otherwise only around a character in flight
  always_ff @(posedge mclk) begin
    if (sys_rst) rts <= 1'b1;
    else rts <= (rts_mode == RTS_ALWAYS) | tx_start | tx_busy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loss of communication: silence counted in whole milliseconds
  wire logic loss_seen = detect_en & (silence_ms > LOSS_LIM);

  always_ff @(posedge mclk) begin
    if (sys_rst || frame_end_ok) silence_ms <= '0;
    else if (ms_tick && silence_ms <= LOSS_LIM) silence_ms <= silence_ms + 16'h1;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      comm_fault   <= 1'b0;
      stop_action  <= ACT_ALARM;
      stop_request <= 1'b0;
    end else begin
      comm_fault   <= loss_seen | (comm_fault & ~fault_clr);
      stop_action  <= action_set;
      stop_request <= comm_fault & (action_set != ACT_ALARM);
    end
  end

endmodule

// [logic/serial_link_pkg.sv]
// Purpose: Shared constants, types and helpers for the serial link supervisor.
// Assumes: 20 MHz mclk, byte-addressed Avalon-MM register window.
// Notes:   Register fields sit in byte lane 0, except the active settings in bits 12:0; upper bits read as zero.
package serial_link_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS         = 1_000_000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int COMM_LOSS_MS  = 2000;
  // About 3.5 character times of silence closes a frame
  localparam logic [5:0] FRAME_GAP_BITS = 6'h28;

  localparam int BPS_1200  = 1200;
  localparam int BPS_2400  = 2400;
  localparam int BPS_4800  = 4800;
  localparam int BPS_9600  = 9600;
  localparam int BPS_19200 = 19200;

  ////////////////////////////////////////////////////////////////////////////
  // Setting codes, ranges and reset values
  localparam logic [7:0] NODE_DEFAULT   = 8'h1f;
  localparam logic [7:0] NODE_MAX       = 8'h20;
  localparam logic [2:0] RATE_DEFAULT   = 3'h3;
  localparam logic [7:0] RATE_MAX       = 8'h04;
  localparam logic [1:0] PAR_NONE       = 2'h0;
  localparam logic [1:0] PAR_EVEN       = 2'h1;
  localparam logic [1:0] PAR_ODD        = 2'h2;
  localparam logic [7:0] PARITY_MAX     = 8'h02;
  localparam logic [1:0] ACT_RAMP       = 2'h0;
  localparam logic [1:0] ACT_COAST      = 2'h1;
  localparam logic [1:0] ACT_FAST       = 2'h2;
  localparam logic [1:0] ACT_ALARM      = 2'h3;
  localparam logic [7:0] ACTION_MAX     = 8'h03;
  localparam logic       DETECT_DEFAULT = 1'b1;
  localparam logic [7:0] BOOL_MAX       = 8'h01;
  localparam logic [6:0] DELAY_DEFAULT  = 7'h05;
  localparam logic [7:0] DELAY_MIN      = 8'h05;
  localparam logic [7:0] DELAY_MAX      = 8'h41;
  localparam logic       RTS_ALWAYS     = 1'b0;
  localparam logic       RTS_DEFAULT    = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [5:0] OFF_NODE    = 6'h00;
  localparam logic [5:0] OFF_RATE    = 6'h04;
  localparam logic [5:0] OFF_PARITY  = 6'h08;
  localparam logic [5:0] OFF_ACTION  = 6'h0c;
  localparam logic [5:0] OFF_DETECT  = 6'h10;
  localparam logic [5:0] OFF_DELAY   = 6'h14;
  localparam logic [5:0] OFF_RTS     = 6'h18;
  localparam logic [5:0] OFF_CONTROL = 6'h1c;
  localparam logic [5:0] OFF_STATUS  = 6'h20;
  localparam logic [5:0] OFF_RX_DATA = 6'h24;
  localparam logic [5:0] OFF_TX_DATA = 6'h28;
  localparam logic [5:0] OFF_ACTIVE  = 6'h2c;

  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_CLEAR_BIT   = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [7:0] node;
    logic [2:0] rate;
    logic [1:0] parity;
  } link_cfg_t;

  typedef struct packed {
    logic in_frame;
    logic comm_fault;
    logic tx_busy;
    logic tx_ready;
    logic rx_parity_err;
    logic rx_overrun;
    logic rx_valid;
  } status_t;

  typedef enum logic [2:0] {CH_IDLE, CH_START, CH_DATA, CH_PARITY, CH_STOP} char_state_t;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [14:0] bps_cycles(input int bps);
    return 15'((CLK_HZ + bps / 2) / bps);
  endfunction

  // Rounded clocks per bit for a rate code
  function automatic logic [14:0] bit_period_cycles(input logic [2:0] code);
    logic [14:0] p;
    case (code)
      3'h0:    p = bps_cycles(BPS_1200);
      3'h1:    p = bps_cycles(BPS_2400);
      3'h2:    p = bps_cycles(BPS_4800);
      3'h4:    p = bps_cycles(BPS_19200);
      default: p = bps_cycles(BPS_9600);
    endcase
    return p;
  endfunction

endpackage

// [logic/uart_char_engine.sv]
// Purpose: Character transmitter and receiver, 8 data bits, optional parity, 1 stop.
// Assumes: rxd_sync already passed two flip-flops.
// Notes:   Rate and parity are taken from cfg continuously.
`timescale 1ns/100ps
module uart_char_engine (
  input  wire logic                  mclk,          // System clock
  input  wire logic                  sys_rst,       // Synchronous reset, high
  input  wire logic                  rxd_sync,      // Synchronised receive line
  input  wire serial_link_pkg::link_cfg_t cfg,      // Active link settings
  input  wire logic                  tx_start,      // Pulse: send tx_byte
  input  wire logic [7:0]            tx_byte,       // Byte to send
  output logic                       txd,           // Transmit line
  output logic                       tx_busy,       // Character in flight
  output logic                       bit_tick,      // Pulse once per bit time
  output logic                       rx_strobe,     // Pulse: rx_byte valid
  output logic [7:0]                 rx_byte,       // Received byte
  output logic                       rx_parity_err  // Parity of rx_byte was wrong
);
  import serial_link_pkg::*;

  wire logic [14:0] period   = bit_period_cycles(cfg.rate);
  wire logic [14:0] last_cnt = period - 15'h1;
  wire logic [14:0] half_cnt = period >> 1;
  wire logic        par_on   = (cfg.parity != PAR_NONE);
  wire logic        par_odd  = (cfg.parity == PAR_ODD);

  logic [14:0] tick_cnt;
  char_state_t tx_state;
  logic [14:0] tx_cnt;
  logic [2:0]  tx_bits;
  logic [7:0]  tx_shift;
  logic        tx_par;
  char_state_t rx_state;
  logic [14:0] rx_cnt;
  logic [2:0]  rx_bits;
  logic [7:0]  rx_shift;

  wire logic tx_bit_end = (tx_cnt == last_cnt);
  wire logic rx_bit_end = (rx_cnt == last_cnt);

  ////////////////////////////////////////////////////////////////////////////
  // Free-running bit-time enable for gap timing
  always_ff @(posedge mclk) begin
    if (sys_rst || tick_cnt >= last_cnt) begin
      tick_cnt <= '0;
      bit_tick <= ~sys_rst;
    end else begin
      tick_cnt <= tick_cnt + 15'h1;
      bit_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_state <= CH_IDLE;
      txd      <= 1'b1;
      tx_busy  <= 1'b0;
      tx_cnt   <= '0;
      tx_bits  <= '0;
      tx_shift <= '0;
      tx_par   <= 1'b0;
    end else begin
      tx_cnt <= (tx_state == CH_IDLE || tx_bit_end) ? '0 : tx_cnt + 15'h1;
      case (tx_state)
        CH_IDLE: if (tx_start) begin
          tx_shift <= tx_byte;
          tx_par   <= ^tx_byte ^ par_odd;
          txd      <= 1'b0;
          tx_busy  <= 1'b1;
          tx_state <= CH_START;
        end
        CH_START: if (tx_bit_end) begin
          txd      <= tx_shift[0];
          tx_shift <= tx_shift >> 1;
          tx_bits  <= '0;
          tx_state <= CH_DATA;
        end
        CH_DATA: if (tx_bit_end) begin
          if (tx_bits == 3'h7) begin
            txd      <= par_on ? tx_par : 1'b1;
            tx_state <= par_on ? CH_PARITY : CH_STOP;
          end else begin
            txd      <= tx_shift[0];
            tx_shift <= tx_shift >> 1;
            tx_bits  <= tx_bits + 3'h1;
          end
        end
        CH_PARITY: if (tx_bit_end) begin
          txd      <= 1'b1;
          tx_state <= CH_STOP;
        end
        CH_STOP: if (tx_bit_end) begin
          tx_busy  <= 1'b0;
          tx_state <= CH_IDLE;
        end
        default: tx_state <= CH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver; bits sampled mid-cell, a low stop bit drops the byte
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_state      <= CH_IDLE;
      rx_cnt        <= '0;
      rx_bits       <= '0;
      rx_shift      <= '0;
      rx_strobe     <= 1'b0;
      rx_byte       <= '0;
      rx_parity_err <= 1'b0;
    end else begin
      rx_strobe <= 1'b0;
      rx_cnt    <= (rx_state == CH_IDLE || rx_bit_end) ? '0 : rx_cnt + 15'h1;
      case (rx_state)
        CH_IDLE: if (!rxd_sync) rx_state <= CH_START;
        CH_START: if (rx_cnt == half_cnt) begin
          rx_cnt   <= '0;
          rx_bits  <= '0;
          rx_state <= rxd_sync ? CH_IDLE : CH_DATA;
        end
        CH_DATA: if (rx_bit_end) begin
          rx_shift <= {rxd_sync, rx_shift[7:1]};
          rx_bits  <= rx_bits + 3'h1;
          if (rx_bits == 3'h7) rx_state <= par_on ? CH_PARITY : CH_STOP;
        end
        CH_PARITY: if (rx_bit_end) begin
          rx_parity_err <= (rxd_sync != (^rx_shift ^ par_odd));
          rx_state      <= CH_STOP;
        end
        CH_STOP: if (rx_bit_end) begin
          rx_strobe <= rxd_sync;
          rx_byte   <= rx_shift;
          if (!par_on) rx_parity_err <= 1'b0;
          rx_state  <= CH_IDLE;
        end
        default: rx_state <= CH_IDLE;
      endcase
    end
  end

endmodule

// [verification/modbus_master_model.sv]
// Purpose: Serial master sending request characters.
// Assumes: 8 data bits, optional parity, 1 stop; line idles high.
// Notes:   Bit period in clocks is a parameter.
`timescale 1ns/100ps
module modbus_master_model #(
  parameter int BIT_CYCLES = 1042 // Clocks per bit at 19200 bps
) (
  input wire logic mclk, // Clock
  output logic     line  // Receive pin
);
  initial line = 1'b1;
  task automatic send(input logic [7:0] b, input logic [1:0] par);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    if (par != 2'h0) f[9] = ^b ^ (par == 2'h2);
    for (int i = 0; i < (par != 2'h0 ? 11 : 10); i++) begin
      line <= f[i];
      repeat (BIT_CYCLES) @(posedge mclk);
    end
  endtask
endmodule

// [verification/serial_link_config_supervisor_bench.sv]
// Purpose: Self-checking bench for the serial link supervisor.
// Assumes: Short millisecond and loss counts.
// Notes:   One frame at 19200 bps keeps the run short.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module serial_link_config_supervisor_bench;
  import serial_link_pkg::*;
  localparam int MS = 20;
  logic        mclk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, rxd;
  logic [5:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic        avs_waitrequest, txd, rts, comm_fault, stop_request;
  logic [1:0]  stop_action;
  int          num_errors = 0, check_count = 0, n;
  always #25 mclk = ~mclk;
  modbus_master_model part_u (.mclk(mclk), .line(rxd));
  serial_link_config_supervisor #(.MS_TICK_CYCLES(MS), .LOSS_LIMIT_MS(5)) dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd),
    .rts(rts), .comm_fault(comm_fault), .stop_action(stop_action), .stop_request(stop_request));
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic guard(input int b);
    if (n >= b) begin
      num_errors++;
      results();
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic wait_txd;
    n = 0;
    while (txd !== 1'b0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    guard(400);
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
    guard(50);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h0);
    `CHK(q, e)
  endtask
  task automatic t_loss;
    n = 0;
    while (comm_fault !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    guard(300);
    `CHK(n > 5 * MS && n <= 6 * MS + 10, 1'b1)
    `CHK(stop_request, 1'b0)
    $display("test loss done");
  endtask
  task automatic t_regs;
    `CHK(rts, 1'b0)
    `CHK(stop_action, ACT_ALARM)
    rd(OFF_NODE, 32'h1f);
    rd(OFF_RATE, 32'h3);
    rd(OFF_PARITY, 32'h0);
    rd(OFF_DETECT, 32'h1);
    rd(OFF_DELAY, 32'h5);
    rd(OFF_RTS, 32'h1);
    rd(6'h30, 32'h0);
    bus(1'b1, OFF_NODE, 8'h21);
    rd(OFF_NODE, 32'h1f);
    bus(1'b1, OFF_NODE, 8'h20);
    rd(OFF_NODE, 32'h20);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFF_RATE, 8'(i));
      rd(OFF_RATE, 32'(i < 5 ? i : 4));
    end
    for (int i = 3; i >= 0; i--) begin
      bus(1'b1, OFF_PARITY, 8'(i));
      rd(OFF_PARITY, 32'(i == 3 ? 0 : i));
    end
    bus(1'b1, OFF_PARITY, 8'h1);
    rd(OFF_ACTIVE, {19'h0, 8'h1f, 3'h3, 2'h0});
    bus(1'b1, OFF_CONTROL, 8'h1);
    rd(OFF_ACTIVE, {19'h0, 8'h20, 3'h4, 2'h1});
    $display("test regs done");
  endtask
  task automatic t_action;
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFF_ACTION, 8'(i));
      tick(2);
      `CHK(stop_action, 2'(i < 4 ? i : 3))
      `CHK(stop_request, i < 3)
    end
    bus(1'b1, OFF_DETECT, 8'h0);
    bus(1'b1, OFF_CONTROL, 8'h2);
    tick(10 * MS);
    `CHK(comm_fault, 1'b0)
    bus(1'b1, OFF_RTS, 8'h0);
    tick(2);
    `CHK(rts, 1'b1)
    bus(1'b1, OFF_RTS, 8'h1);
    tick(2);
    `CHK(rts, 1'b0)
    $display("test action done");
  endtask
  task automatic t_frame;
    logic [9:0] r;
    int p;
    part_u.send(8'h20, PAR_EVEN);
    // Own poll counter: bus reuses n
    p = 0;
    do begin
      bus(1'b0, OFF_STATUS, 8'h0);
      p++;
    end while (q[6] !== 1'b0 && p < 20000);
    n = p;
    guard(20000);
    `CHK(q[2:0], 3'h1)
    bus(1'b1, OFF_TX_DATA, 8'h5a);
    wait_txd();
    `CHK(n > 4 * MS + 5 && n <= 5 * MS + 5, 1'b1)
    `CHK(rts, 1'b1)
    tick(521);
    for (int i = 0; i < 10; i++) begin
      tick(1042);
      r[i] = txd;
    end
    `CHK(r, {1'b1, ^8'h5a, 8'h5a})
    rd(OFF_RX_DATA, 32'h20);
    tick(1042);
    `CHK(rts, 1'b0)
    $display("test frame done");
  endtask
  initial begin
    tick(10);
    sys_rst <= 1'b0;
    t_loss();
    t_regs();
    t_action();
    t_frame();
    results();
  end
endmodule

// [verification/serial_link_props.sv]
// Purpose: Port checks for the serial link supervisor.
// Assumes: Top module ports only.
// Notes:   Bound at the foot.
`timescale 1ns/100ps
module serial_link_props
  import serial_link_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter int LOSS_LIMIT_MS  = COMM_LOSS_MS
) (
  input wire logic        mclk,            // Clock
  input wire logic        sys_rst,         // Reset
  input wire logic [5:0]  avs_address,     // Address
  input wire logic        avs_read,        // Read
  input wire logic        avs_write,       // Write
  input wire logic [31:0] avs_readdata,    // Read data
  input wire logic        avs_waitrequest, // Stall
  input wire logic        txd,             // Transmit
  input wire logic        rts,             // Request-to-send
  input wire logic        comm_fault,      // Fault
  input wire logic [1:0]  stop_action,     // Action
  input wire logic        stop_request     // Stop
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire done   = avs_write && !avs_waitrequest;
  wire ctl_wr = done && avs_address == OFF_CONTROL;
  wire act_wr = done && avs_address == OFF_ACTION;

  chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 6'h2c |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  chk_fault_sticky: assert property (comm_fault && !ctl_wr |=> comm_fault)
    else $error("fault dropped");
  chk_stop_req: assert property ($past(comm_fault) && stop_action != ACT_ALARM |-> stop_request)
    else $error("stop not requested");
  chk_no_stop: assert property (!$past(comm_fault) |-> !stop_request)
    else $error("stop without fault");
  chk_alarm_only: assert property (stop_action == ACT_ALARM && $stable(stop_action) |-> !stop_request)
    else $error("stop in alarm mode");
  chk_rts_tx: assert property (!txd |-> rts)
    else $error("sending without rts");
  chk_rts_fall: assert property ($fell(rts) |-> txd && $past(txd))
    else $error("rts dropped mid character");
  chk_action_src: assert property ($changed(stop_action) |-> $past(act_wr) || $past(act_wr, 2))
    else $error("action changed unprompted");

  cover property ($rose(comm_fault));
  cover property (stop_request);
  cover property (!txd);
endmodule

bind serial_link_config_supervisor serial_link_props #(
  .MS_TICK_CYCLES(MS_TICK_CYCLES), .LOSS_LIMIT_MS(LOSS_LIMIT_MS)
) props_u (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .txd, .rts, .comm_fault, .stop_action, .stop_request);
